//--- questionable_status_and_srq.sv
module questionable_status_and_srq
  import status_report_pkg::*;
#(
  parameter int DEPTH = ERRQ_DEPTH
) (
  // Clock and reset.
  input  wire logic            mclk,
  input  wire logic            rst_n,
  // Instrument condition levels, asynchronous to mclk.
  input  wire cond_pins_type   pins,
  // Parser requests on mclk.
  input  wire req_type         req,
  // Register views.
  output status_view_type      view,
  // Service request and buffer control.
  output logic                 srq,
  output logic                 outbuf_clear,
  output logic                 input_flush,
  output logic                 settings_reset
);

  // ****************************************************************
  // State.
  // ****************************************************************
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // Status byte and event byte are 8 bits, questionable parts 16.
  typedef struct packed {
    logic [PIN_W-1:0]                s1;
    logic [PIN_W-1:0]                s2;
    logic [PIN_W-1:0]                s3;
    logic [PIN_W-1:0]                filt;
    logic [QUES_W-1:0]               cond;
    logic [QUES_W-1:0]               qev;
    logic [QUES_W-1:0]               qen;
    logic [QUES_W-1:0]               ptr;
    logic [QUES_W-1:0]               ntr;
    logic [BYTE_W-1:0]               esr;
    logic [BYTE_W-1:0]               sre;
    logic [BYTE_W-1:0]               ese;
    logic [BYTE_W-1:0]               stb;
    logic [DEPTH-1:0][ERR_W-1:0]     errq;
    logic [PTR_W-1:0]                rd;
    logic [PTR_W-1:0]                wr;
    logic [PTR_W:0]                  cnt;
    logic                            pend;
    logic                            obclr;
    logic                            inflush;
    logic                            setrst;
  } state_type;

  state_type q;
  state_type d;

  // Advances a queue pointer with wrap at the queue depth.
  function automatic logic [PTR_W-1:0] inc_ptr(input logic [PTR_W-1:0] p);
    if (p == PTR_W'(DEPTH - 1)) begin
      return '0;
    end
    return p + PTR_W'(1);
  endfunction : inc_ptr

  // Maps the filtered condition levels onto questionable bit positions.
  function automatic logic [QUES_W-1:0] map_cond(input cond_pins_type c);
    logic [QUES_W-1:0] v;
    v = '0;
    v[QB_PROBE_SUPPLY] = c.probe_supply_overload;
    v[QB_PROBE_OVER]   = c.probe_over_range;
    v[QB_CHAN_OVER]    = c.channel_over_range;
    v[QB_TEMPERATURE]  = c.temp_questionable;
    v[QB_CLIPPING]     = c.converter_clipping;
    v[QB_GEN_OVER]     = c.generator_over_range;
    v[QB_UNCAL]        = c.uncalibrated_flag;
    v[QB_LIMIT]        = c.limit_violated;
    v[QB_MARGIN]       = c.margin_violated & ~c.limit_violated;
    v[QB_LOW_SIGNAL]   = c.low_signal_unreliable;
    v[QB_LOCK_LOST]    = c.loop_lock_lost;
    return v & QUES_VALID;
  endfunction : map_cond

  // ****************************************************************
  // Next state.
  // ****************************************************************
  // All register updates are computed here from the current state.
  always_comb begin
    logic [QUES_W-1:0] rise;
    logic [QUES_W-1:0] fall;
    logic              qclr;
    logic              eclr;
    logic [PTR_W-1:0]  rd;
    logic [PTR_W-1:0]  wr;
    logic [PTR_W:0]    cnt;
    logic [BYTE_W-1:0] sb;
    rise = '0;
    fall = '0;
    qclr = 1'b0;
    eclr = 1'b0;
    rd   = q.rd;
    wr   = q.wr;
    cnt  = q.cnt;
    sb   = '0;
    d    = q;

    // Three-stage synchroniser; a level counts once stages two and three agree.
    d.s1   = pins;
    d.s2   = q.s1;
    d.s3   = q.s2;
    d.filt = (~(q.s2 ^ q.s3) & q.s3) | ((q.s2 ^ q.s3) & q.filt);
    d.cond = map_cond(cond_pins_type'(q.filt));

    rise = d.cond & ~q.cond & q.ptr;
    fall = ~d.cond & q.cond & q.ntr;
    qclr = req.ques_event_read | req.clear_status;
    eclr = req.esr_read | req.clear_status;
    // Event part latches; a new edge beats the clear.
    d.qev = ((q.qev & ~{QUES_W{qclr}}) | rise | fall) & QUES_VALID;
    d.esr = (q.esr & ~{BYTE_W{eclr}}) | req.esr_set;

    // Mask writes; the enable masks survive clear status and device clear, but a status preset reloads the questionable enable.
    if (req.sre_write) begin
      d.sre = req.wdata[BYTE_W-1:0];
    end
    if (req.ese_write) begin
      d.ese = req.wdata[BYTE_W-1:0];
    end
    if (req.ques_enable_write) begin
      d.qen = req.wdata & QUES_VALID;
    end
    if (req.ques_ptr_write) begin
      d.ptr = req.wdata;
    end
    if (req.ques_ntr_write) begin
      d.ntr = req.wdata;
    end
    if (req.status_preset) begin
      d.qen = QUES_EN_RST;
      d.ptr = QUES_PTR_RST;
      d.ntr = QUES_NTR_RST;
    end

    if (req.clear_status) begin
      rd  = '0;
      wr  = '0;
      cnt = '0;
    end else if (req.err_pop && (q.cnt != '0)) begin
      rd  = inc_ptr(q.rd);
      cnt = q.cnt - (PTR_W + 1)'(1);
    end
    if (req.err_push && (cnt < (PTR_W + 1)'(DEPTH))) begin
      d.errq[wr] = req.err_code;
      wr         = inc_ptr(wr);
      cnt        = cnt + (PTR_W + 1)'(1);
    end
    d.rd  = rd;
    d.wr  = wr;
    d.cnt = cnt;

    // Summary bits of questionable, events, error queue, message and operation, and the request bit.
    sb[SB_QUES] = |(d.qev & d.qen);
    sb[SB_ESB]  = |(d.esr & d.ese);
    sb[SB_ERRQ] = (cnt != '0);
    sb[SB_MAV]  = req.msg_avail;
    sb[SB_OPER] = req.oper_summary;
    sb[SB_RQS]  = |(sb & d.sre & SRQ_SOURCES);
    d.stb       = sb;

    // Pending flush until the next command.
    d.pend  = (q.pend & ~req.first_cmd_after_term) | req.clear_status |
              req.status_preset | req.rst_preset;
    d.obclr   = req.device_clear | (q.pend & req.first_cmd_after_term);
    d.inflush = req.device_clear;
    d.setrst  = req.rst_preset;
  end

  // ****************************************************************
  // Registers.
  // ****************************************************************
  // Power-on reset loads the power-on defaults; only the positive masks start at one.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q     <= '0;
      q.ptr <= QUES_PTR_RST;
    end else begin
      q <= d;
    end
  end

  // Register views and pulses come from flops; err_head, err_nonempty and err_full are decoded from the queue flops.
  assign view.stb          = q.stb;
  assign view.esr          = q.esr;
  assign view.sre          = q.sre;
  assign view.ese          = q.ese;
  assign view.ques_cond    = q.cond;
  assign view.ques_event   = q.qev;
  assign view.ques_enable  = q.qen;
  assign view.ques_ptr     = q.ptr;
  assign view.ques_ntr     = q.ntr;
  assign view.err_head     = q.errq[q.rd];
  assign view.err_nonempty = (q.cnt != '0);
  assign view.err_full     = (q.cnt == (PTR_W + 1)'(DEPTH));
  assign srq               = q.stb[SB_RQS];
  assign outbuf_clear      = q.obclr;
  assign input_flush       = q.inflush;
  assign settings_reset    = q.setrst;

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  sequence s_supply_held;
    pins.probe_supply_overload [*4];
  endsequence

  sequence s_cls_then_cmd;
    req.clear_status ##1 (req.first_cmd_after_term && !req.status_preset &&
                          !req.rst_preset && !req.clear_status);
  endsequence

  // Held supply overload reaches bit.
  // The level needs three sync stages plus the filter and condition flops.
  a_supply_bit_set: assert property (s_supply_held |=> ##1 view.ques_cond[QB_PROBE_SUPPLY])
    else $error("probe supply overload not reported");

  a_margin_excl: assert property (view.ques_cond[QB_MARGIN] |-> !view.ques_cond[QB_LIMIT])
    else $error("margin bit set together with limit bit");

  a_reserved_zero: assert property (((view.ques_cond | view.ques_event) & ~QUES_VALID) == '0)
    else $error("reserved questionable bit set");

  a_rise_latch: assert property ((d.cond & ~q.cond & q.ptr) != '0 |=>
                                 (view.ques_event & $past(d.cond & ~q.cond & q.ptr)) != '0)
    else $error("enabled rising condition not latched");

  a_srq_ques: assert property ((view.ques_event & view.ques_enable) != '0 &&
                               view.sre[SB_QUES] && $stable(view.sre) |-> ##[0:1] srq)
    else $error("service request missing for enabled questionable event");

  a_cls_clears: assert property (req.clear_status && req.esr_set == '0 && !req.err_push
                                 && !req.sre_write |=> view.esr == '0 &&
                                 !view.err_nonempty && $stable(view.sre))
    else $error("clear status left state or changed mask");

  a_preset_masks: assert property (req.status_preset |=> view.ques_enable == QUES_EN_RST &&
                                   view.ques_ptr == QUES_PTR_RST &&
                                   view.ques_ntr == QUES_NTR_RST)
    else $error("status preset masks wrong");

  a_dcl_flush: assert property (req.device_clear |=> outbuf_clear && input_flush)
    else $error("device clear did not flush buffers");

  a_cls_cmd_flush: assert property (s_cls_then_cmd |=> outbuf_clear)
    else $error("first command after clear did not flush output");

  a_settings_src: assert property (settings_reset |-> $past(req.rst_preset))
    else $error("settings reset without reset request");

  a_err_push: assert property (req.err_push && !req.err_pop && !req.clear_status &&
                               !view.err_full |=> q.cnt == $past(q.cnt) + 1'b1)
    else $error("error entry not queued");

endmodule : questionable_status_and_srq

//--- status_report_pkg.sv
// ****************************************************************
// Shared constants and carriers for the status reporting block.
// ****************************************************************
package status_report_pkg;

  // Register widths: status byte and standard events are 8 bits, condition pins 11, the rest 16.
  localparam int QUES_W   = 16;
  localparam int BYTE_W   = 8;
  localparam int ERR_W    = 16;
  localparam int PIN_W    = 11;

  // Bit positions inside the questionable register.
  localparam int QB_PROBE_SUPPLY = 1;
  localparam int QB_PROBE_OVER   = 2;
  localparam int QB_CHAN_OVER    = 3;
  localparam int QB_TEMPERATURE  = 4;
  localparam int QB_CLIPPING     = 5;
  localparam int QB_GEN_OVER     = 6;
  localparam int QB_UNCAL        = 8;
  localparam int QB_LIMIT        = 9;
  localparam int QB_MARGIN       = 10;
  localparam int QB_LOW_SIGNAL   = 11;
  localparam int QB_LOCK_LOST    = 13;

  // Bit positions inside the status byte.
  localparam int SB_ERRQ  = 2;
  localparam int SB_QUES  = 3;
  localparam int SB_MAV   = 4;
  localparam int SB_ESB   = 5;
  localparam int SB_RQS   = 6;
  localparam int SB_OPER  = 7;

  // Implemented questionable bits; 0, 7, 12, 14 and 15 read zero in the condition, event and enable parts.
  localparam logic [QUES_W-1:0] QUES_VALID    = 16'h2F7E;
  // Status byte bits that may raise a service request.
  localparam logic [BYTE_W-1:0] SRQ_SOURCES   = 8'hBC;
  // Values after power-on reset; all but MASK8_RST also after a status preset.
  localparam logic [QUES_W-1:0] QUES_EN_RST   = 16'h0000;
  localparam logic [QUES_W-1:0] QUES_PTR_RST  = 16'hFFFF;
  localparam logic [QUES_W-1:0] QUES_NTR_RST  = 16'h0000;
  localparam logic [BYTE_W-1:0] MASK8_RST     = 8'h00;
  // Default depth of the error queue.
  localparam int ERRQ_DEPTH = 8;

  // Condition inputs from the instrument, one level each.
  typedef struct packed {
    logic probe_supply_overload;
    logic probe_over_range;
    logic channel_over_range;
    logic temp_questionable;
    logic converter_clipping;
    logic generator_over_range;
    logic uncalibrated_flag;
    logic limit_violated;
    logic margin_violated;
    logic low_signal_unreliable;
    logic loop_lock_lost;
  } cond_pins_type;

  // Requests from the command parser, all on mclk; strobes last one cycle.
  typedef struct packed {
    logic                clear_status;
    logic                status_preset;
    logic                device_clear;
    logic                rst_preset;
    logic                first_cmd_after_term;
    logic                ques_event_read;
    logic                esr_read;
    logic                sre_write;
    logic                ese_write;
    logic                ques_enable_write;
    logic                ques_ptr_write;
    logic                ques_ntr_write;
    logic                err_push;
    logic                err_pop;
    logic [ERR_W-1:0]    err_code;
    logic [QUES_W-1:0]   wdata;
    logic [BYTE_W-1:0]   esr_set;
    logic                msg_avail;
    logic                oper_summary;
  } req_type;

  // Register views returned to the parser.
  typedef struct packed {
    logic [BYTE_W-1:0]   stb;
    logic [BYTE_W-1:0]   esr;
    logic [BYTE_W-1:0]   sre;
    logic [BYTE_W-1:0]   ese;
    logic [QUES_W-1:0]   ques_cond;
    logic [QUES_W-1:0]   ques_event;
    logic [QUES_W-1:0]   ques_enable;
    logic [QUES_W-1:0]   ques_ptr;
    logic [QUES_W-1:0]   ques_ntr;
    logic [ERR_W-1:0]    err_head;
    logic                err_nonempty;
    logic                err_full;
  } status_view_type;

endpackage : status_report_pkg

//--- controller_model.sv
// ****************************************************************
// Remote controller model issuing parser requests.
// ****************************************************************
module controller_model
  import status_report_pkg::*;
(
  // Clock.
  input  wire logic mclk,
  // Requests to the block.
  output req_type   req
);
  timeunit 1ns;
  timeprecision 1ps;

  // Nothing is requested until the bench asks.
  initial req = '0;

  // Raises one strobe over a single rising edge, with its data held alongside.
  task automatic send(input int op, input logic [15:0] d);
    req_type r;
    @(negedge mclk);
    req.wdata    = d;
    req.err_code = d;
    req.esr_set  = (op == 14) ? d[7:0] : 8'h00;
    case (op)
      0: req.clear_status = 1'b1;
      1: req.status_preset = 1'b1;
      2: req.device_clear = 1'b1;
      3: req.rst_preset = 1'b1;
      4: req.first_cmd_after_term = 1'b1;
      5: req.ques_event_read = 1'b1;
      6: req.esr_read = 1'b1;
      7: req.sre_write = 1'b1;
      8: req.ese_write = 1'b1;
      9: req.ques_enable_write = 1'b1;
      10: req.ques_ptr_write = 1'b1;
      11: req.ques_ntr_write = 1'b1;
      12: req.err_push = 1'b1;
      13: req.err_pop = 1'b1;
      default: ;
    endcase
    @(negedge mclk);
    // The strobes drop in one assignment; the summary levels are kept.
    r = '0;
    r.msg_avail = req.msg_avail;
    r.oper_summary = req.oper_summary;
    req = r;
  endtask : send

  // Sets the two summary levels that the controller side reports.
  task automatic levels(input logic ma, input logic os);
    @(negedge mclk);
    req.msg_avail = ma;
    req.oper_summary = os;
  endtask : levels

  task automatic enable_all();
    send(7, 16'h00FF);
    send(8, 16'h00FF);
    send(9, 16'hFFFF);
  endtask : enable_all

endmodule : controller_model

//--- testbench.sv
// ****************************************************************
// Self-checking bench for the status reporting block.
// ****************************************************************
module testbench
  import status_report_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int DQ = 4;
  localparam int CLS = 0, PRE = 1, DCL = 2, RST = 3, FIRST = 4, QEV = 5;
  localparam int SRE = 7, PTR = 10, NTR = 11, PUSH = 12, POP = 13, ESET = 14;

  logic            mclk;
  logic            rst_n;
  cond_pins_type   pins;
  req_type         req;
  status_view_type view;
  logic            srq;
  logic            outbuf_clear;
  logic            input_flush;
  logic            settings_reset;
  int              num_errors;
  int              num_checks;
  int              cycles;
  int              seed;
  int              qb[11] = '{1, 2, 3, 4, 5, 6, 8, 9, 10, 11, 13};

  controller_model ctl (.mclk(mclk), .req(req));

  questionable_status_and_srq #(.DEPTH(DQ)) uut (
    .mclk(mclk), .rst_n(rst_n), .pins(pins), .req(req), .view(view),
    .srq(srq), .outbuf_clear(outbuf_clear), .input_flush(input_flush),
    .settings_reset(settings_reset));

  // Clock at 25 MHz.
  initial mclk = 1'b0;
  always #20 mclk = ~mclk;

  // Cuts a hang short.
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      end_sim();
    end
  end

  // Expected condition word for a set of pin levels.
  function automatic logic [15:0] exp_cond(input cond_pins_type p);
    logic [15:0] e;
    e = 16'h0000;
    for (int i = 0; i < 11; i++) e[qb[i]] = p[10-i];
    if (p.limit_violated) e[10] = 1'b0;
    return e;
  endfunction : exp_cond

  // Compares one value and reports a difference.
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask : cyc

  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim

  // Main sequence.
  initial begin
    num_errors = 0;
    num_checks = 0;
    cycles = 0;
    seed = 31376;
    pins = '0;
    rst_n = 1'b0;
    cyc(19);
    chk("ptr_rst", view.ques_ptr, 16'hFFFF);
    chk("en_rst", view.ques_enable, 16'h0000);
    chk("srq_rst", {15'h0, srq}, 16'h0000);
    cyc(1);
    rst_n = 1'b1;
    cyc(2);
    for (int i = 0; i < 11; i++) begin
      pins = cond_pins_type'(11'h400 >> i);
      cyc(5);
      chk("cond_bit", view.ques_cond, 16'h0001 << qb[i]);
      pins = '0;
      cyc(5);
    end
    chk("event_all", view.ques_event, 16'h2F7E);
    chk("cond_off", view.ques_cond & 16'h5081, 16'h0000);
    pins.limit_violated = 1'b1;
    pins.margin_violated = 1'b1;
    cyc(5);
    chk("margin", view.ques_cond, 16'h0200);
    for (int i = 0; i < 20; i++) begin
      pins = cond_pins_type'($random(seed));
      cyc(5);
      chk("cond_rnd", view.ques_cond, exp_cond(pins));
    end
    pins = '0;
    cyc(5);
    ctl.send(QEV, 16'h0000);
    chk("event_rd", view.ques_event, 16'h0000);
    ctl.send(PTR, 16'h0000);
    ctl.send(NTR, 16'h0002);
    pins.probe_supply_overload = 1'b1;
    cyc(5);
    chk("ev_rise", view.ques_event, 16'h0000);
    pins = '0;
    cyc(5);
    chk("ev_fall", view.ques_event, 16'h0002);
    ctl.enable_all();
    chk("stb_q", {15'h0, view.stb[3]}, 16'h0001);
    ctl.send(SRE, 16'h0040);
    chk("srq_b6", {15'h0, srq}, 16'h0000);
    ctl.send(ESET, 16'h0004);
    chk("stb_e", {15'h0, view.stb[5]}, 16'h0001);
    ctl.send(PUSH, 16'hBEEF);
    chk("err_h", view.err_head, 16'hBEEF);
    ctl.levels(1'b1, 1'b1);
    cyc(1);
    chk("stb_all", {8'h00, view.stb & 8'hBC}, 16'h00BC);
    foreach (qb[i]) begin
      if (i < 5) begin
        ctl.send(SRE, 16'h0001 << ((i == 4) ? 7 : i + 2));
        chk("srq_src", {15'h0, srq}, 16'h0001);
      end
    end
    // queue fills, drops, drains in order.
    for (int k = 1; k < DQ; k++) ctl.send(PUSH, 16'(k));
    chk("err_full", {15'h0, view.err_full}, 16'h0001);
    ctl.send(PUSH, 16'h0009);
    ctl.send(POP, 16'h0000);
    for (int k = 1; k < DQ; k++) begin
      chk("err_ord", view.err_head, 16'(k));
      ctl.send(POP, 16'h0000);
    end
    chk("err_mt", {15'h0, view.err_nonempty}, 16'h0000);
    ctl.send(PUSH, 16'h0005);
    ctl.send(SRE, 16'h00FF);
    ctl.levels(1'b0, 1'b0);
    ctl.send(CLS, 16'h0000);
    chk("cls_esr", {8'h00, view.esr}, 16'h0000);
    chk("cls_ev", view.ques_event, 16'h0000);
    chk("cls_err", {15'h0, view.err_nonempty}, 16'h0000);
    chk("cls_stb", {8'h00, view.stb}, 16'h0000);
    chk("cls_sre", {view.sre, view.ese}, 16'hFFFF);
    ctl.send(FIRST, 16'h0000);
    chk("ob_first", {15'h0, outbuf_clear}, 16'h0001);
    ctl.send(PRE, 16'h0000);
    chk("pre_en", view.ques_enable, 16'h0000);
    chk("pre_ptr", view.ques_ptr, 16'hFFFF);
    chk("pre_ntr", view.ques_ntr, 16'h0000);
    chk("pre_sre", {view.sre, view.ese}, 16'hFFFF);
    ctl.send(DCL, 16'h0000);
    chk("dcl", {13'h0, outbuf_clear, input_flush, settings_reset}, 16'h0006);
    cyc(1);
    chk("dcl_end", {14'h0, outbuf_clear, input_flush}, 16'h0000);
    ctl.send(RST, 16'h0000);
    chk("rst_set", {15'h0, settings_reset}, 16'h0001);
    end_sim();
  end

endmodule : testbench
